// ===== hdl/tspm_base_mem.sv
`timescale 1ns/10ps

module tspm_base_mem #(
  parameter int DW = 16,
  parameter int AW = 9
) (
  input  wire logic          ref_clk,
  input  wire logic          clk_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  // no reset: baseline content is undefined until the init pass fills it
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule

// ===== hdl/tspm_ctrl.sv
`timescale 1ns/10ps
`include "tspm_defs.svh"

module tspm_ctrl
  import tspm_pkg::*;
#(
  parameter int           MS_CYC     = `TSPM_MS_CYC,
  parameter int           WAKE_CYC   = `TSPM_WAKE_MIN_CYC,
  parameter int           NUM_FREQ   = `TSPM_NUM_FREQ,
  parameter int           CHAN_AW    = 9,
  parameter int           INIT_SCANS = `TSPM_INIT_SCANS,
  parameter tspm_sample_t DRIFT_THR  = `TSPM_DRIFT_THR
) (
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               clk_en,
  input  wire logic [3:0]         cfg_fast_ms,
  input  wire logic [3:0]         cfg_idle_s,
  input  wire logic               cfg_trig_mode,
  input  wire logic               sleep_cmd,
  input  wire logic               scan_done,
  input  wire logic               touch_seen,
  input  wire logic               noise_hit,
  input  wire logic               sensor_valid,
  input  wire logic [CHAN_AW-1:0] sensor_chan,
  input  wire tspm_sample_t       sensor_data,
  input  wire logic               int_in,
  output logic                    int_out,
  output logic                    int_oe,
  output logic                    scan_start,
  output tspm_mode_e              mode,
  output logic [2:0]              drive_freq,
  output logic                    calib_done,
  output logic                    base_upd,
  output logic [CHAN_AW-1:0]      base_chan,
  output tspm_sample_t            base_val
);

  localparam int MSW = $clog2(MS_CYC + 1);
  localparam int WKW = $clog2(WAKE_CYC + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tspm_mode_e         mode_reg;
  logic [MSW-1:0]     ms_cnt_reg;
  logic [5:0]         scan_ms_reg;
  logic               scan_start_reg;
  logic [9:0]         idle_ms_reg;
  logic [3:0]         idle_s_reg;
  logic [WKW-1:0]     wake_cnt_reg;
  logic               int_oe_reg;
  logic [10:0]        notify_cnt_reg;
  logic [10:0]        notify_cnt_next;
  logic               int_out_reg;
  logic [2:0]         drive_freq_reg;
  logic [7:0]         calib_ms_reg;
  logic [3:0]         init_scans_reg;
  logic               calib_done_reg;
  logic               pend_reg;
  logic               pend_touch_reg;
  logic [CHAN_AW-1:0] pend_chan_reg;
  tspm_sample_t       pend_data_reg;
  logic               base_upd_reg;
  logic [CHAN_AW-1:0] base_chan_reg;
  tspm_sample_t       base_val_reg;
  tspm_sample_t       mem_rd_data;

  logic ms_tick;
  logic awake;
  logic touch_evt;
  logic wake_hit;
  logic scan_last;

  // clamp the configured fast period into its legal range
  function automatic logic [5:0] tspm_period(tspm_mode_e m, logic [3:0] sel);
    logic [5:0] p;
    p = {2'h0, sel};
    if (m == TSPM_GREEN) begin
      p = 6'(`TSPM_GREEN_MS);
    end else if (p < 6'(`TSPM_FAST_MIN_MS)) begin
      p = 6'(`TSPM_FAST_MIN_MS);
    end else if (p > 6'(`TSPM_FAST_MAX_MS)) begin
      p = 6'(`TSPM_FAST_MAX_MS);
    end
    return p;
  endfunction

  assign ms_tick   = (ms_cnt_reg == MSW'(MS_CYC - 1));
  assign awake     = (mode_reg != TSPM_SLEEP);
  assign touch_evt = awake && scan_done && touch_seen;
  assign wake_hit  = !awake && int_in && (wake_cnt_reg == WKW'(WAKE_CYC - 1));
  assign scan_last = (scan_ms_reg >= tspm_period(mode_reg, cfg_fast_ms) - 6'h01);

  // ----------------------------------------------------------------
  // millisecond time base
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ms_cnt_reg <= '0;
    end else if (clk_en) begin
      ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + MSW'(1);
    end
  end

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mode_reg   <= TSPM_FAST;
      int_oe_reg <= `TSPM_OE_RST;
    end else if (clk_en) begin
      unique case (mode_reg)
        TSPM_FAST: begin
          if (sleep_cmd) begin
            mode_reg   <= TSPM_SLEEP;
            int_oe_reg <= 1'b0;
          end else if (scan_done && !touch_seen && idle_s_reg >= cfg_idle_s) begin
            mode_reg <= TSPM_GREEN;
          end
        end
        TSPM_GREEN: begin
          if (sleep_cmd) begin
            mode_reg   <= TSPM_SLEEP;
            int_oe_reg <= 1'b0;
          end else if (scan_done && touch_seen) begin
            mode_reg <= TSPM_FAST;
          end
        end
        TSPM_SLEEP: begin
          if (wake_hit) begin
            mode_reg   <= TSPM_FAST;
            int_oe_reg <= 1'b1;
          end
        end
        default: begin
          mode_reg   <= TSPM_FAST;
          int_oe_reg <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // scan scheduler
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      scan_ms_reg    <= 6'h00;
      scan_start_reg <= 1'b0;
    end else if (clk_en) begin
      scan_start_reg <= 1'b0;
      if (!awake) begin
        scan_ms_reg <= 6'h00;
      end else if (mode_reg == TSPM_GREEN && scan_done && touch_seen) begin
        // restart the count so the first fast period is not a stale green count
        scan_ms_reg <= 6'h00;
      end else if (ms_tick) begin
        if (scan_last) begin
          scan_ms_reg    <= 6'h00;
          scan_start_reg <= 1'b1;
        end else begin
          scan_ms_reg <= scan_ms_reg + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // idle timeout, whole seconds without a touch
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      idle_ms_reg <= 10'h000;
      idle_s_reg  <= 4'h0;
    end else if (clk_en) begin
      if (mode_reg != TSPM_FAST || touch_evt) begin
        idle_ms_reg <= 10'h000;
        idle_s_reg  <= 4'h0;
      end else if (ms_tick) begin
        if (idle_ms_reg == 10'(`TSPM_S_MS - 1)) begin
          idle_ms_reg <= 10'h000;
          // saturates: timeout is checked only at scan ends
          if (idle_s_reg != 4'(`TSPM_IDLE_MAX_S)) begin
            idle_s_reg <= idle_s_reg + 4'h1;
          end
        end else begin
          idle_ms_reg <= idle_ms_reg + 10'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // wake detection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wake_cnt_reg <= '0;
    end else if (clk_en) begin
      if (awake || !int_in) begin
        wake_cnt_reg <= '0;
      end else if (wake_cnt_reg != WKW'(WAKE_CYC - 1)) begin
        wake_cnt_reg <= wake_cnt_reg + WKW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // touch notification
  // ----------------------------------------------------------------
  // a touch during a running pulse is dropped: retriggering hides the edge
  always_comb begin
    notify_cnt_next = notify_cnt_reg;
    if (touch_evt && notify_cnt_reg == 11'h000) begin
      notify_cnt_next = 11'(`TSPM_NOTIFY_CYC);
    end else if (notify_cnt_reg != 11'h000) begin
      notify_cnt_next = notify_cnt_reg - 11'h001;
    end
  end

  // polarity is live; changing it mid-pulse makes a stray edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      notify_cnt_reg <= 11'h000;
      int_out_reg    <= `TSPM_TRIG_RISE;
    end else if (clk_en) begin
      notify_cnt_reg <= notify_cnt_next;
      int_out_reg    <= (notify_cnt_next != 11'h000) ? !cfg_trig_mode : cfg_trig_mode;
    end
  end

  // ----------------------------------------------------------------
  // frequency hopping
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      drive_freq_reg <= `TSPM_FREQ_RST;
    end else if (clk_en && awake && noise_hit) begin
      drive_freq_reg <= (drive_freq_reg == 3'(NUM_FREQ - 1)) ? 3'h0 : drive_freq_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // initial calibration
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      calib_ms_reg   <= 8'h00;
      init_scans_reg <= 4'h0;
      calib_done_reg <= 1'b0;
    end else if (clk_en && !calib_done_reg) begin
      if (ms_tick) begin
        calib_ms_reg <= calib_ms_reg + 8'h01;
      end
      if (scan_done && awake) begin
        init_scans_reg <= init_scans_reg + 4'h1;
      end
      // deadline forces completion even if scans stall
      if ((ms_tick && calib_ms_reg == 8'(`TSPM_CALIB_MS - 1)) ||
          (scan_done && awake && init_scans_reg == 4'(INIT_SCANS - 1))) begin
        calib_done_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // baseline store and drift tracking
  // ----------------------------------------------------------------
  logic               take;
  logic               init_wr;
  logic               drift_up;
  tspm_sample_t       drift_mag;
  logic               drift_wr;
  logic               mem_wr;
  logic [CHAN_AW-1:0] mem_wr_addr;
  tspm_sample_t       mem_wr_data;

  assign take      = clk_en && awake && sensor_valid;
  assign init_wr   = take && !calib_done_reg;
  assign drift_up  = pend_data_reg > mem_rd_data;
  assign drift_mag = drift_up ? pend_data_reg - mem_rd_data : mem_rd_data - pend_data_reg;
  // large steps without touch are not followed: only slow drift tracks
  assign drift_wr  = pend_reg && !pend_touch_reg && drift_mag != 16'h0000 &&
                     drift_mag <= DRIFT_THR;
  assign mem_wr      = drift_wr || init_wr;
  assign mem_wr_addr = drift_wr ? pend_chan_reg : sensor_chan;
  assign mem_wr_data = drift_wr ? (drift_up ? mem_rd_data + 16'h0001 : mem_rd_data - 16'h0001)
                                : sensor_data;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pend_reg       <= 1'b0;
      pend_touch_reg <= 1'b0;
      pend_chan_reg  <= '0;
      pend_data_reg  <= 16'h0000;
    end else if (clk_en) begin
      pend_reg       <= take && calib_done_reg;
      pend_touch_reg <= touch_seen;
      pend_chan_reg  <= sensor_chan;
      pend_data_reg  <= sensor_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      base_upd_reg  <= 1'b0;
      base_chan_reg <= '0;
      base_val_reg  <= 16'h0000;
    end else if (clk_en) begin
      base_upd_reg <= mem_wr;
      if (mem_wr) begin
        base_chan_reg <= mem_wr_addr;
        base_val_reg  <= mem_wr_data;
      end
    end
  end

  tspm_base_mem #(
    .DW (16),
    .AW (CHAN_AW)
  ) u_base_mem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .wr_en   (mem_wr),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_en   (take),
    .rd_addr (sensor_chan),
    .rd_data (mem_rd_data)
  );

  assign int_out    = int_out_reg;
  assign int_oe     = int_oe_reg;
  assign scan_start = scan_start_reg;
  assign mode       = mode_reg;
  assign drive_freq = drive_freq_reg;
  assign calib_done = calib_done_reg;
  assign base_upd   = base_upd_reg;
  assign base_chan  = base_chan_reg;
  assign base_val   = base_val_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  fast_min_period_a: assert property (
    (clk_en && ms_tick && mode_reg == TSPM_FAST && scan_ms_reg < 6'd6) |=> !scan_start_reg)
    else $error("fast scan came before 7 ms");
  fast_max_period_a: assert property (
    mode_reg == TSPM_FAST |-> scan_ms_reg < 6'd10)
    else $error("fast scan period exceeds 10 ms");
  green_entry_a: assert property (
    (clk_en && mode_reg == TSPM_FAST && !sleep_cmd && scan_done && !touch_seen &&
     idle_s_reg >= cfg_idle_s) |=> mode_reg == TSPM_GREEN)
    else $error("idle timeout did not enter green mode");
  green_period_a: assert property (
    (clk_en && ms_tick && mode_reg == TSPM_GREEN && scan_ms_reg == 6'd39) |=> scan_start_reg)
    else $error("green scan not on 40 ms cycle");
  green_exit_a: assert property (
    (clk_en && mode_reg == TSPM_GREEN && !sleep_cmd && scan_done && touch_seen)
    |=> mode_reg == TSPM_FAST)
    else $error("touch in green mode did not return to fast");
  wake_return_a: assert property (
    (clk_en && wake_hit) |=> (mode_reg == TSPM_FAST && int_oe_reg))
    else $error("wake pulse did not return to fast mode");
  notify_edge_a: assert property (
    (clk_en && touch_evt && notify_cnt_reg == 11'h000) |=> int_out_reg == !$past(cfg_trig_mode))
    else $error("notify level does not match polarity");
  no_spurious_a: assert property (
    (clk_en && notify_cnt_reg == 11'h000 && !touch_evt) |=> int_out_reg == $past(cfg_trig_mode))
    else $error("interrupt line moved without a touch");
  freq_hop_a: assert property (
    (clk_en && awake && noise_hit) |=> drive_freq_reg != $past(drive_freq_reg))
    else $error("noise did not change drive frequency");
  calib_bound_a: assert property (
    !calib_done_reg |-> calib_ms_reg < 8'd200)
    else $error("baseline init ran past 200 ms");
  drift_step_a: assert property (
    (clk_en && drift_wr) |=> (base_upd_reg &&
      (base_val_reg == $past(mem_rd_data) + 16'h0001 ||
       base_val_reg == $past(mem_rd_data) - 16'h0001)))
    else $error("drift update is not a single step");
  sleep_quiet_a: assert property (
    (mode_reg == TSPM_SLEEP && $past(mode_reg) == TSPM_SLEEP) |-> (!scan_start_reg && !int_oe_reg))
    else $error("activity while asleep");

  green_entry_c: cover property (mode_reg == TSPM_FAST ##1 mode_reg == TSPM_GREEN);
  wake_c:        cover property (mode_reg == TSPM_SLEEP ##1 mode_reg == TSPM_FAST);
  notify_c:      cover property (clk_en && touch_evt && notify_cnt_reg == 11'h000);
  drift_c:       cover property (clk_en && drift_wr);

endmodule

// ===== hdl/tspm_defs.svh
`ifndef TSPM_DEFS_SVH
`define TSPM_DEFS_SVH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define TSPM_CLK_PERIOD_NS 8
`define TSPM_MS_NS         1000000
`define TSPM_MS_CYC        (`TSPM_MS_NS / `TSPM_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// scan timing, in ms
// ----------------------------------------------------------------
`define TSPM_FAST_MIN_MS   7
`define TSPM_FAST_MAX_MS   10
`define TSPM_GREEN_MS      40

// ----------------------------------------------------------------
// idle timeout, calibration, wake and notify timing
// ----------------------------------------------------------------
`define TSPM_S_MS          1000
`define TSPM_IDLE_MAX_S    15
`define TSPM_CALIB_MS      200
`define TSPM_WAKE_MIN_MS   2
`define TSPM_WAKE_MAX_MS   5
`define TSPM_WAKE_MIN_CYC  ((`TSPM_WAKE_MIN_MS * `TSPM_MS_NS + `TSPM_CLK_PERIOD_NS - 1) / `TSPM_CLK_PERIOD_NS)
`define TSPM_NOTIFY_NS     10000
`define TSPM_NOTIFY_CYC    ((`TSPM_NOTIFY_NS + `TSPM_CLK_PERIOD_NS - 1) / `TSPM_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// reset values, encodings and parameter defaults
// ----------------------------------------------------------------
`define TSPM_TRIG_RISE     1'b0
`define TSPM_TRIG_FALL     1'b1
`define TSPM_FREQ_RST      3'h0
`define TSPM_OE_RST        1'b1
`define TSPM_INIT_SCANS    2
`define TSPM_DRIFT_THR     16'h0040
`define TSPM_NUM_FREQ      5

`endif

// ===== hdl/tspm_pkg.sv
package tspm_pkg;

  typedef enum logic [1:0] {
    TSPM_FAST  = 2'b00,
    TSPM_GREEN = 2'b01,
    TSPM_SLEEP = 2'b10
  } tspm_mode_e;

  typedef logic [15:0] tspm_sample_t;

endpackage

// ===== test/tspm_ctrl_tb_top.sv
`timescale 1ns/10ps

module tspm_ctrl_tb_top
  import tspm_pkg::*;
;
  // ----
  // signals
  // ----
  localparam int MS   = 10;
  localparam int WAKE = 20;

  logic         ref_clk;
  logic         rstn;
  logic         clk_en;
  logic [3:0]   cfg_fast_ms;
  logic [3:0]   cfg_idle_s;
  logic         cfg_trig_mode;
  logic         sleep_cmd;
  logic         scan_done;
  logic         touch_seen;
  logic         noise_hit;
  logic         sensor_valid;
  logic [8:0]   sensor_chan;
  tspm_sample_t sensor_data;
  logic         int_in;
  logic         int_out;
  logic         int_oe;
  logic         scan_start;
  tspm_mode_e   mode;
  logic [2:0]   drive_freq;
  logic         calib_done;
  logic         base_upd;
  logic [8:0]   base_chan;
  tspm_sample_t base_val;
  logic [8:0]   ch_seen;
  tspm_sample_t val_seen;
  int           failures;
  int           tests_run;

  tspm_ctrl #(.MS_CYC(MS), .WAKE_CYC(WAKE)) tspm_ctrl_i (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .clk_en        (clk_en),
    .cfg_fast_ms   (cfg_fast_ms),
    .cfg_idle_s    (cfg_idle_s),
    .cfg_trig_mode (cfg_trig_mode),
    .sleep_cmd     (sleep_cmd),
    .scan_done     (scan_done),
    .touch_seen    (touch_seen),
    .noise_hit     (noise_hit),
    .sensor_valid  (sensor_valid),
    .sensor_chan   (sensor_chan),
    .sensor_data   (sensor_data),
    .int_in        (int_in),
    .int_out       (int_out),
    .int_oe        (int_oe),
    .scan_start    (scan_start),
    .mode          (mode),
    .drive_freq    (drive_freq),
    .calib_done    (calib_done),
    .base_upd      (base_upd),
    .base_chan     (base_chan),
    .base_val      (base_val)
  );

  tspm_host_model tspm_host_model_i (
    .ref_clk       (ref_clk),
    .int_out       (int_out),
    .int_oe        (int_oe),
    .int_in        (int_in),
    .sleep_cmd     (sleep_cmd),
    .cfg_trig_mode (cfg_trig_mode)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----
  // helpers
  // ----
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic final_report();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    tick(3);
    rstn <= 1'b1;
    @(posedge ref_clk);
  endtask

  task automatic scan(input logic t);
    @(posedge ref_clk);
    scan_done <= 1'b1;
    touch_seen <= t;
    @(posedge ref_clk);
    scan_done <= 1'b0;
    touch_seen <= 1'b0;
  endtask

  task automatic noise();
    @(posedge ref_clk);
    noise_hit <= 1'b1;
    @(posedge ref_clk);
    noise_hit <= 1'b0;
  endtask

  task automatic sample(input logic [8:0] c, input tspm_sample_t d, input logic t,
                        output logic seen);
    @(posedge ref_clk);
    sensor_valid <= 1'b1;
    sensor_chan <= c;
    sensor_data <= d;
    touch_seen <= t;
    @(posedge ref_clk);
    sensor_valid <= 1'b0;
    touch_seen <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge ref_clk);
      if (base_upd === 1'b1 && !seen) begin
        seen = 1'b1;
        ch_seen = base_chan;
        val_seen = base_val;
      end
    end
  endtask

  // interval between two start pulses, after syncing to the first
  task automatic meas(output int n);
    int k;
    k = 0;
    while (scan_start !== 1'b1 && k < 1000) begin
      @(posedge ref_clk);
      k++;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (scan_start !== 1'b1 && n < 1000);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_calib_timer();
    int n;
    do_reset();
    chk("mode", TSPM_FAST, mode);
    chk("int_oe", 16'h1, int_oe);
    chk("int_out", 16'h0, int_out);
    chk("drive_freq", 16'h0, drive_freq);
    chk("calib_done", 16'h0, calib_done);
    n = 0;
    while (calib_done !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("calib by timer", 16'h1, n >= 200 * MS - 10 && n <= 200 * MS + 10);
  endtask

  task automatic t_init_calib();
    logic s;
    do_reset();
    sample(9'h005, 16'h1000, 1'b0, s);
    chk("init update", 16'h1, s);
    chk("init value", 16'h1000, val_seen);
    sample(9'h006, 16'h2000, 1'b0, s);
    sample(9'h007, 16'h3000, 1'b0, s);
    scan(1'b0);
    scan(1'b0);
    tick(2);
    chk("calib by scans", 16'h1, calib_done);
  endtask

  // small drift follows, large jump, no change or touched sample do not
  task automatic t_drift();
    logic         s;
    logic [8:0]   c [5] = '{9'h005, 9'h006, 9'h007, 9'h006, 9'h007};
    tspm_sample_t d [5] = '{16'h1020, 16'h2041, 16'h3000, 16'h2010, 16'h3040};
    logic         t [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic         e [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    tspm_sample_t v [5] = '{16'h1001, 16'h0000, 16'h0000, 16'h0000, 16'h3001};
    for (int i = 0; i < 5; i++) begin
      sample(c[i], d[i], t[i], s);
      chk("drift update", e[i], s);
      if (e[i]) begin
        chk("drift chan", c[i], ch_seen);
        chk("drift value", v[i], val_seen);
      end
    end
  endtask

  task automatic t_noise();
    for (int i = 1; i <= 6; i++) begin
      noise();
      tick(2);
      chk("drive_freq", 16'(i % 5), drive_freq);
    end
    // enable low must freeze the hop
    clk_en <= 1'b0;
    noise();
    tick(2);
    chk("frozen freq", 16'h1, drive_freq);
    clk_en <= 1'b1;
  endtask

  task automatic t_fast();
    int n;
    logic [3:0] cf [4] = '{4'h7, 4'hA, 4'hC, 4'h3};
    int         ex [4] = '{7, 10, 10, 7};
    for (int i = 0; i < 4; i++) begin
      cfg_fast_ms <= cf[i];
      meas(n);
      meas(n);
      chk("fast period", 16'(ex[i] * MS), 16'(n));
    end
  endtask

  task automatic t_notify(input logic trig);
    int n;
    tspm_host_model_i.set_trig(trig);
    chk("int idle", trig, int_out);
    scan(1'b0);
    n = 0;
    repeat (20) begin
      @(posedge ref_clk);
      if (int_out !== trig) n++;
    end
    chk("no notify", 16'h0, 16'(n));
    scan(1'b1);
    n = 0;
    while (int_out === trig && n < 5) begin
      @(posedge ref_clk);
      n++;
    end
    chk("notify edge", !trig, int_out);
    n = 0;
    while (int_out !== trig && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("notify width", 16'h1, n >= 1249 && n <= 1252);
  endtask

  task automatic t_green();
    int n;
    cfg_idle_s <= 4'h1;
    scan(1'b1);
    tick(1300);
    scan(1'b0);
    tick(2);
    chk("mode before timeout", TSPM_FAST, mode);
    tick(1000 * MS + 50);
    scan(1'b0);
    tick(2);
    chk("mode after timeout", TSPM_GREEN, mode);
    meas(n);
    meas(n);
    chk("green period", 16'(40 * MS), 16'(n));
    scan(1'b1);
    tick(2);
    chk("mode after touch", TSPM_FAST, mode);
    cfg_idle_s <= 4'hF;
    tick(1300);
  endtask

  task automatic t_sleep();
    int n;
    logic s;
    logic [2:0] f;
    tspm_host_model_i.enter_sleep();
    tick(2);
    chk("sleep mode", TSPM_SLEEP, mode);
    chk("sleep oe", 16'h0, int_oe);
    f = drive_freq;
    scan(1'b1);
    noise();
    sample(9'h005, 16'h1030, 1'b0, s);
    n = 0;
    repeat (500) begin
      @(posedge ref_clk);
      if (scan_start === 1'b1 || base_upd === 1'b1) n++;
    end
    chk("sleep activity", 16'h0, 16'(n) | 16'(s));
    chk("sleep freq", f, drive_freq);
    chk("sleep held", TSPM_SLEEP, mode);
    tspm_host_model_i.wake(WAKE / 2);
    tick(4);
    chk("short wake", TSPM_SLEEP, mode);
    tspm_host_model_i.wake(WAKE + 5);
    tick(2);
    chk("wake mode", TSPM_FAST, mode);
    chk("wake oe", 16'h1, int_oe);
    tspm_host_model_i.release_line();
    tick(2);
  endtask

  // ----
  // main sequence and watchdog
  // ----
  initial begin
    failures = 0;
    tests_run = 0;
    rstn = 1'b0;
    clk_en = 1'b1;
    cfg_fast_ms = 4'h7;
    cfg_idle_s = 4'hF;
    scan_done = 1'b0;
    touch_seen = 1'b0;
    noise_hit = 1'b0;
    sensor_valid = 1'b0;
    sensor_chan = 9'h000;
    sensor_data = 16'h0000;
    t_calib_timer();
    t_init_calib();
    t_drift();
    t_noise();
    t_fast();
    t_notify(1'b0);
    t_notify(1'b1);
    t_green();
    t_sleep();
    final_report();
  end

  // roughly twice the expected run length
  initial begin
    tick(40000);
    failures++;
    $display("mismatch watchdog expected finish seen timeout");
    final_report();
  end
endmodule

// ===== test/tspm_host_model.sv
`timescale 1ns/10ps

module tspm_host_model (
  input  wire logic ref_clk,
  input  wire logic int_out,
  input  wire logic int_oe,
  output logic      int_in,
  output logic      sleep_cmd,
  output logic      cfg_trig_mode
);
  // ----
  // interrupt wire
  // ----
  logic host_oe;
  logic host_lvl;
  logic float_lvl;

  initial begin
    host_oe = 1'b0;
    host_lvl = 1'b0;
    float_lvl = 1'b0;
    sleep_cmd = 1'b0;
    cfg_trig_mode = 1'b0;
  end

  // no pull on the line: a floating wire wanders, so it never fakes a wake
  always @(posedge ref_clk) begin
    float_lvl <= ~float_lvl;
  end

  // host wins a clash, since it holds the line through sleep entry and wake
  assign int_in = host_oe ? host_lvl : (int_oe ? int_out : float_lvl);

  // ----
  // host actions
  // ----
  task automatic set_trig(input logic m);
    @(posedge ref_clk);
    cfg_trig_mode <= m;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic enter_sleep();
    @(posedge ref_clk);
    host_oe <= 1'b1;
    host_lvl <= 1'b0;
    repeat (3) @(posedge ref_clk);
    sleep_cmd <= 1'b1;
    @(posedge ref_clk);
    sleep_cmd <= 1'b0;
  endtask

  // short highs are issued on purpose to prove they are not taken as wake
  task automatic wake(input int n);
    @(posedge ref_clk);
    host_lvl <= 1'b1;
    repeat (n) @(posedge ref_clk);
    host_lvl <= 1'b0;
  endtask

  task automatic release_line();
    @(posedge ref_clk);
    host_oe <= 1'b0;
  endtask
endmodule
